// ### rtl/cbf_pkg.sv
// Constants shared by the proximity reader frame layer
package cbf_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int ETU_NS = 9440;
	localparam int ETU_CYC = (ETU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HALF_ETU_CYC = ETU_CYC / 2;
	localparam int SUBC_PERIOD_NS = 1180;
	localparam int SILENCE_SUBC = 128;
	localparam int SILENCE_NS = SILENCE_SUBC * SUBC_PERIOD_NS;
	// Longest quiet time the tag is sure to keep, so round down
	localparam int SILENCE_CYC = SILENCE_NS / CLK_PERIOD_NS;
	localparam int TURN_ETU = 10;
	localparam int TURN_CYC = TURN_ETU * ETU_CYC;
	localparam int TIMEOUT_CYC = 200000;
	localparam int CARRIER_HALF_CYC = 7;
	// ----------------------------------------
	// Frame shape, counted in time units
	// ----------------------------------------
	localparam logic [3:0] SOF_LOW_ETU = 4'h000a;
	localparam logic [3:0] SOF_HIGH_ETU = 4'h0002;
	localparam logic [3:0] SOF_HIGH_MAX_ETU = 4'h0003;
	localparam logic [3:0] EOF_LOW_ETU = 4'h000a;
	localparam logic [3:0] CHAR_BITS = 4'h000a;
	localparam logic START_BIT = 1'h0;
	localparam logic STOP_BIT = 1'h1;
	// ----------------------------------------
	// Frame check and transmit FIFO
	// ----------------------------------------
	localparam logic [15:0] CRC_PRESET = 16'hffff;
	localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
	localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_WIDTH = 9;
endpackage

// ### rtl/cbf_reader.sv
// Reader side frame layer of a 106 kbit/s proximity link, with its transmit FIFO
`timescale 1ns/100ps

module cbf_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	always_comb begin
		in_ready = (count != (AW+1)'(DEPTH));
		out_valid = (count != '0);
		out_data = mem[rd_ptr];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1)) : wr_ptr;
		next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1)) : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule

module cbf_reader #(
	parameter int ETU_CYC = cbf_pkg::ETU_CYC,
	parameter int SILENCE_CYC = cbf_pkg::SILENCE_CYC,
	parameter int TURN_CYC = cbf_pkg::TURN_CYC,
	parameter int TIMEOUT_CYC = cbf_pkg::TIMEOUT_CYC,
	parameter int CARRIER_HALF_CYC = cbf_pkg::CARRIER_HALF_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_end,
	output logic rx_crc_ok,
	output logic busy,
	output logic carrier_out,
	output logic tx_mod,
	input wire logic rx_line
);
	// ----------------------------------------
	// Types and helpers
	// ----------------------------------------
	typedef enum logic [3:0] {
		CBF_IDLE = 4'h0000, CBF_SOFL = 4'h0001, CBF_SOFH = 4'h0003,
		CBF_LOAD = 4'h0002, CBF_TXCH = 4'h0006, CBF_EOFL = 4'h0007,
		CBF_QUIET = 4'h0005, CBF_HUNT = 4'h0004, CBF_RSOFL = 4'h000c,
		CBF_RSOFH = 4'h000d, CBF_RCHAR = 4'h000f, CBF_RGAP = 4'h000e,
		CBF_TURN = 4'h000a
	} cbf_state_t;

	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc;
		for (int i = 0; i < 8; i++) begin
			c = (c[0] ^ data[i]) ? ((c >> 1) ^ cbf_pkg::CRC_POLY_REFL) : (c >> 1);
		end
		return c;
	endfunction

	// ----------------------------------------
	// Transmit FIFO
	// ----------------------------------------
	logic f_valid, f_ready;
	logic [8:0] f_data;

	cbf_fifo #(
		.WIDTH(cbf_pkg::FIFO_WIDTH),
		.DEPTH(cbf_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data({tx_last, tx_data}),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);

	// ----------------------------------------
	// Carrier divider and line synchroniser
	// ----------------------------------------
	logic [7:0] div_cnt, next_div_cnt;
	logic next_carrier;
	logic rx_meta, rx_sync, rx_prev;

	always_comb begin
		next_div_cnt = div_cnt + 8'h0001;
		next_carrier = carrier_out;
		if (div_cnt == 8'(CARRIER_HALF_CYC - 1)) begin
			next_div_cnt = '0;
			next_carrier = !carrier_out;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			div_cnt <= '0;
			carrier_out <= 1'b0;
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			div_cnt <= next_div_cnt;
			carrier_out <= next_carrier;
			rx_meta <= rx_line;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
		end
	end

	// ----------------------------------------
	// Frame engine
	// ----------------------------------------
	cbf_state_t state, next_state;
	logic [15:0] etu_cnt, next_etu_cnt;
	logic [3:0] units, next_units;
	logic [23:0] wait_cnt, next_wait_cnt;
	logic [9:0] shift, next_shift;
	logic [15:0] crc, next_crc;
	logic [1:0] sel, next_sel;
	logic [1:0] nbytes, next_nbytes;
	logic last, next_last;
	logic next_tx_mod, next_rx_valid, next_rx_end, next_rx_crc_ok;
	logic [7:0] next_rx_data;
	logic etu_done, mid_bit, fall, rise;

	always_comb begin
		etu_done = (etu_cnt == 16'(ETU_CYC - 1));
		mid_bit = (etu_cnt == 16'(ETU_CYC / 2));
		fall = rx_prev && !rx_sync;
		rise = !rx_prev && rx_sync;
		busy = (state != CBF_IDLE);
		f_ready = (state == CBF_LOAD) && (sel == 2'h0);
		next_state = state;
		next_etu_cnt = etu_done ? '0 : etu_cnt + 16'h0001;
		next_units = units;
		next_wait_cnt = wait_cnt + 24'h0001;
		next_shift = shift;
		next_crc = crc;
		next_sel = sel;
		next_nbytes = nbytes;
		next_last = last;
		next_tx_mod = tx_mod;
		next_rx_valid = 1'b0;
		next_rx_data = rx_data;
		next_rx_end = 1'b0;
		next_rx_crc_ok = rx_crc_ok;
		if (etu_done) begin
			next_units = units + 4'h0001;
		end
		unique case (state)
			CBF_IDLE: begin
				next_tx_mod = 1'b1;
				if (f_valid) begin
					next_state = CBF_SOFL;
					next_etu_cnt = '0;
					next_units = '0;
					next_crc = cbf_pkg::CRC_PRESET;
					next_sel = 2'h0;
					next_tx_mod = 1'b0;
				end
			end
			CBF_SOFL: begin
				if (etu_done && units == cbf_pkg::SOF_LOW_ETU - 4'h0001) begin
					next_state = CBF_SOFH;
					next_units = '0;
					next_tx_mod = 1'b1;
				end
			end
			CBF_SOFH: begin
				if (etu_done && units == cbf_pkg::SOF_HIGH_ETU - 4'h0001) begin
					next_state = CBF_LOAD;
				end
			end
			CBF_LOAD: begin
				// Line idles high while the FIFO runs dry, as extra guard time
				next_tx_mod = 1'b1;
				next_etu_cnt = '0;
				next_units = '0;
				if (sel == 2'h0 && f_valid) begin
					next_shift = {cbf_pkg::STOP_BIT, f_data[7:0], cbf_pkg::START_BIT};
					next_crc = crc_step(crc, f_data[7:0]);
					next_last = f_data[8];
					next_state = CBF_TXCH;
				end else if (sel == 2'h1) begin
					next_shift = {cbf_pkg::STOP_BIT, ~crc[7:0], cbf_pkg::START_BIT};
					next_state = CBF_TXCH;
				end else if (sel == 2'h2) begin
					next_shift = {cbf_pkg::STOP_BIT, ~crc[15:8], cbf_pkg::START_BIT};
					next_state = CBF_TXCH;
				end
			end
			CBF_TXCH: begin
				next_tx_mod = shift[0];
				if (etu_done) begin
					next_shift = {1'b1, shift[9:1]};
					if (units == cbf_pkg::CHAR_BITS - 4'h0001) begin
						next_state = CBF_LOAD;
						next_tx_mod = 1'b1;
						if (sel == 2'h2) begin
							next_state = CBF_EOFL;
							next_tx_mod = 1'b0;
							next_etu_cnt = '0;
							next_units = '0;
						end else if (sel == 2'h1 || last) begin
							next_sel = sel + 2'h1;
						end
					end
				end
			end
			CBF_EOFL: begin
				next_tx_mod = 1'b0;
				if (etu_done && units == cbf_pkg::EOF_LOW_ETU - 4'h0001) begin
					next_tx_mod = 1'b1;
					next_state = CBF_QUIET;
					next_wait_cnt = '0;
				end
			end
			CBF_QUIET: begin
				// Tag is silent then sends plain subcarrier; nothing to decode yet
				if (wait_cnt == 24'(SILENCE_CYC - 1)) begin
					next_state = CBF_HUNT;
					next_wait_cnt = '0;
				end
			end
			CBF_HUNT, CBF_RGAP: begin
				next_etu_cnt = '0;
				next_units = '0;
				if (fall) begin
					next_state = (state == CBF_HUNT) ? CBF_RSOFL : CBF_RCHAR;
					next_wait_cnt = '0;
					next_crc = (state == CBF_HUNT) ? cbf_pkg::CRC_PRESET : crc;
					next_nbytes = (state == CBF_HUNT) ? 2'h0 : nbytes;
				end else if (wait_cnt == 24'(TIMEOUT_CYC - 1)) begin
					next_state = CBF_TURN;
					next_wait_cnt = '0;
					next_rx_end = 1'b1;
					next_rx_crc_ok = 1'b0;
				end
			end
			CBF_RSOFL: begin
				if (rise) begin
					// Accept 9 to 11 units low around the nominal 10
					next_state = (units >= cbf_pkg::SOF_LOW_ETU - 4'h0001
						&& units <= cbf_pkg::SOF_LOW_ETU) ? CBF_RSOFH : CBF_HUNT;
					next_etu_cnt = '0;
					next_units = '0;
				end
			end
			CBF_RSOFH: begin
				if (fall) begin
					next_state = (units >= cbf_pkg::SOF_HIGH_ETU - 4'h0001
						&& units <= cbf_pkg::SOF_HIGH_MAX_ETU) ? CBF_RCHAR : CBF_HUNT;
					next_etu_cnt = '0;
					next_units = '0;
				end
			end
			CBF_RCHAR: begin
				if (mid_bit) begin
					next_shift = {rx_sync, shift[9:1]};
					if (units == cbf_pkg::CHAR_BITS - 4'h0001) begin
						next_wait_cnt = '0;
						if (next_shift == '0) begin
							// A character-long low with no stop bit is the closing mark
							next_state = CBF_TURN;
							next_rx_end = 1'b1;
							next_rx_crc_ok = (crc == cbf_pkg::CRC_RESIDUE)
								&& (nbytes == 2'h2);
						end else if (next_shift[0] == cbf_pkg::START_BIT
							&& next_shift[9] == cbf_pkg::STOP_BIT) begin
							next_state = CBF_RGAP;
							next_rx_valid = 1'b1;
							next_rx_data = next_shift[8:1];
							next_crc = crc_step(crc, next_shift[8:1]);
							next_nbytes = (nbytes == 2'h2) ? nbytes : nbytes + 2'h1;
						end else begin
							next_state = CBF_TURN;
							next_rx_end = 1'b1;
							next_rx_crc_ok = 1'b0;
						end
					end
				end
			end
			CBF_TURN: begin
				if (wait_cnt == 24'(TURN_CYC - 1)) begin
					next_state = CBF_IDLE;
				end
			end
			default: begin
				next_state = CBF_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state <= CBF_IDLE;
			etu_cnt <= '0;
			units <= '0;
			wait_cnt <= '0;
			shift <= '1;
			crc <= cbf_pkg::CRC_PRESET;
			sel <= '0;
			nbytes <= '0;
			last <= 1'b0;
			tx_mod <= 1'b1;
			rx_valid <= 1'b0;
			rx_data <= '0;
			rx_end <= 1'b0;
			rx_crc_ok <= 1'b0;
		end else begin
			state <= next_state;
			etu_cnt <= next_etu_cnt;
			units <= next_units;
			wait_cnt <= next_wait_cnt;
			shift <= next_shift;
			crc <= next_crc;
			sel <= next_sel;
			nbytes <= next_nbytes;
			last <= next_last;
			tx_mod <= next_tx_mod;
			rx_valid <= next_rx_valid;
			rx_data <= next_rx_data;
			rx_end <= next_rx_end;
			rx_crc_ok <= next_rx_crc_ok;
		end
	end
endmodule

// ### tb/cbf_reader_bench.sv
// Self-checking bench for the reader frame layer against a tag model
`timescale 1ns/100ps
module cbf_reader_bench;
	// Short time unit keeps the run brief; silence and turnaround scale with it, the reply timeout stays fixed
	localparam int E = 64;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_last = 1'b0;
	logic tx_ready, rx_valid, rx_end, rx_crc_ok, busy, carrier_out, tx_mod, rx_line, req_ok;
	logic [7:0] rx_data, req_first, req_n;
	logic [7:0] first_rx = 8'h00;
	logic [7:0] ans_byte = 8'h5a;
	logic ans_bad = 1'b0;
	logic last_ok = 1'b0;
	int bad_count = 0;
	int n_tests = 0;
	int n_valid = 0;
	int n_end = 0;
	int cyc = 0;
	always #2.5 clock = ~clock;
	// Turnaround outlasts the tag's closing high so it never misses a new opening
	cbf_reader #(.ETU_CYC(E), .SILENCE_CYC(16 * E), .TURN_CYC(4 * E), .TIMEOUT_CYC(30000),
		.CARRIER_HALF_CYC(7)) dut (.clock(clock), .rst(rst), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok), .busy(busy),
		.carrier_out(carrier_out), .tx_mod(tx_mod), .rx_line(rx_line));
	cbf_tag_model #(.E(E)) tag (.clock(clock), .tx_mod(tx_mod), .ans_byte(ans_byte),
		.ans_bad(ans_bad), .rx_line(rx_line), .req_first(req_first), .req_n(req_n),
		.req_ok(req_ok));
	// ----
	// Monitors and run limit
	// ----
	always @(negedge clock) begin
		if (!rst && rx_valid) begin
			if (n_valid % 3 == 0) first_rx = rx_data;
			n_valid++;
		end
		if (!rst && rx_end) begin
			last_ok = rx_crc_ok;
			n_end++;
		end
	end
	// Three requests with their answers take about 500 units, well below this
	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			end_of_test();
		end
	end
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Leaves the strobe up so back-to-back bytes need no gap
	task automatic push(input logic [7:0] d, input logic l);
		tx_valid = 1'b1;
		tx_data = d;
		tx_last = l;
		while (!tx_ready) begin
			@(posedge clock);
			#1;
		end
		@(posedge clock);
		#1;
	endtask
	task automatic wait_end(input int n);
		while (n_end < n) @(posedge clock);
		#1;
	endtask
	task automatic t_exchange;
		@(posedge clock);
		#1;
		push(8'h3c, 1'b1);
		tx_valid = 1'b0;
		wait_end(1);
		chk(req_first, 8'h3c);
		chk(req_n, 8'h03);
		chk(8'(req_ok), 8'h01);
		chk(first_rx, 8'h5a);
		chk(8'(n_valid), 8'h03);
		chk(8'(last_ok), 8'h01);
	endtask
	task automatic t_fill_bad;
		ans_bad = 1'b1;
		push(8'h81, 1'b1);
		tx_valid = 1'b0;
		repeat (13 * E) @(posedge clock);
		#1;
		push(8'h11, 1'b0);
		push(8'h22, 1'b0);
		push(8'h33, 1'b0);
		push(8'h44, 1'b1);
		tx_valid = 1'b0;
		chk(8'(tx_ready), 8'h00);
		wait_end(2);
		chk(req_first, 8'h81);
		chk(8'(last_ok), 8'h00);
		ans_bad = 1'b0;
		wait_end(3);
		chk(req_n, 8'h06);
		chk(req_first, 8'h11);
		chk(8'(last_ok), 8'h01);
		chk(8'(tx_ready), 8'h01);
	endtask
	initial begin
		repeat (2) @(posedge clock);
		#1;
		rst = 1'b0;
		t_exchange();
		t_fill_bad();
		end_of_test();
	end
endmodule

// ### tb/cbf_reader_props.sv
// Port checker for the reader frame layer
`timescale 1ns/100ps
module cbf_reader_props #(
	parameter int ETU_CYC = cbf_pkg::ETU_CYC,
	parameter int SILENCE_CYC = 200,
	parameter int TURN_CYC = 50,
	parameter int TIMEOUT_CYC = 30000,
	parameter int CARRIER_HALF_CYC = 7
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic rx_end,
	input wire logic rx_crc_ok,
	input wire logic busy,
	input wire logic carrier_out,
	input wire logic tx_mod
);
	localparam int E = ETU_CYC;
	logic [15:0] low_len;
	logic [15:0] next_low_len;
	// ----
	// Length of the current low run on the line
	// ----
	always_comb begin
		next_low_len = (rst || tx_mod) ? 16'h0000 : low_len + 16'h0001;
	end
	always_ff @(posedge clock) begin
		low_len <= next_low_len;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_frame_open: assert property ($rose(busy) |-> ##[0:2] !tx_mod)
		else $error("frame did not open low");
	// Only frame marks reach ten units; data lows are whole units
	chk_low_runs: assert property ($rose(tx_mod) |-> low_len == 10 * E
		|| (low_len % E == 0 && low_len <= 9 * E)) else $error("bad low run");
	chk_idle_high: assert property (!busy |-> tx_mod)
		else $error("line low while idle");
	chk_valid_pulse: assert property (rx_valid |=> !rx_valid)
		else $error("byte strobe too long");
	chk_rx_quiet: assert property (rx_valid |-> tx_mod && busy)
		else $error("modulating while receiving");
	chk_end_pulse: assert property (rx_end |=> !rx_end)
		else $error("end strobe too long");
	chk_crc_on_end: assert property (!$stable(rx_crc_ok) |-> rx_end)
		else $error("check flag moved without end");
	chk_turn_wait: assert property (rx_end |=> busy[*8] ##[1:1000] !busy)
		else $error("turnaround wrong");
	chk_carrier_div: assert property ($changed(carrier_out) |=>
		$stable(carrier_out)[*6] ##1 $changed(carrier_out)) else $error("carrier period");
	cover property (rx_valid);
	cover property (rx_end && rx_crc_ok);
	cover property (rx_end && !rx_crc_ok);
	cover property (!tx_ready);
endmodule
bind cbf_reader cbf_reader_props #(.ETU_CYC(ETU_CYC), .SILENCE_CYC(SILENCE_CYC),
	.TURN_CYC(TURN_CYC), .TIMEOUT_CYC(TIMEOUT_CYC),
	.CARRIER_HALF_CYC(CARRIER_HALF_CYC)) u_props (
	.clock(clock), .rst(rst), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_end(rx_end),
	.rx_crc_ok(rx_crc_ok), .busy(busy), .carrier_out(carrier_out), .tx_mod(tx_mod));

// ### tb/cbf_tag_model.sv
// Behavioural proximity tag at the far side of the link
`timescale 1ns/100ps
module cbf_tag_model #(
	// One time unit holds eight subcarrier periods, so 128 periods are 16 units
	parameter int E = cbf_pkg::ETU_CYC,
	parameter int SIL = 16 * E,
	parameter int SYNC = 16 * E
) (
	input wire logic clock,
	input wire logic tx_mod,
	input wire logic [7:0] ans_byte,
	input wire logic ans_bad,
	output logic rx_line,
	output logic [7:0] req_first,
	output logic [7:0] req_n,
	output logic req_ok
);
	logic [15:0] crc;
	logic [9:0] ch;
	logic ok;
	logic done;
	int cnt;
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? (r >> 1) ^ 16'h8408 : r >> 1;
		end
		return r;
	endfunction
	task automatic put(input logic v, input int n);
		rx_line = v;
		repeat (n) @(negedge clock);
	endtask
	task automatic put_char(input logic [7:0] d);
		put(1'b0, E);
		for (int i = 0; i < 8; i++) begin
			put(d[i], E);
		end
		put(1'b1, E);
	endtask
	// ----
	// Sampled on the falling clock edge, clear of the reader's updates
	// ----
	initial begin
		rx_line = 1'b1;
		req_first = 8'h00;
		req_n = 8'h00;
		req_ok = 1'b0;
		forever begin
			@(negedge clock iff !tx_mod);
			cnt = 0;
			while (!tx_mod) begin
				@(negedge clock);
				cnt++;
			end
			ok = cnt > 9 * E && cnt < 11 * E;
			// High part of the opening mark runs up to the first start bit
			cnt = 0;
			while (tx_mod) begin
				@(negedge clock);
				cnt++;
			end
			ok = ok && cnt >= 2 * E && cnt <= 3 * E;
			crc = 16'hffff;
			req_n = 8'h00;
			done = 1'b0;
			while (!done) begin
				@(negedge clock iff !tx_mod);
				repeat (E / 2) @(negedge clock);
				for (int i = 0; i < 10; i++) begin
					ch[i] = tx_mod;
					if (i < 9) repeat (E) @(negedge clock);
				end
				done = ch == 10'h000;
				if (!done) begin
					ok = ok && !ch[0] && ch[9];
					if (req_n == 8'h00) req_first = ch[8:1];
					crc = crc_step(crc, ch[8:1]);
					req_n = req_n + 8'h01;
				end
			end
			@(negedge clock iff tx_mod);
			req_ok = ok && req_n >= 2 && crc == 16'hf0b8;
			// A spoiled request gets no answer at all
			if (req_ok) begin
				put(1'b1, SIL + SYNC);
				put(1'b0, 10 * E);
				put(1'b1, 2 * E);
				crc = ~crc_step(16'hffff, ans_byte);
				put_char(ans_byte);
				put_char(crc[7:0] ^ {7'h00, ans_bad});
				put_char(crc[15:8]);
				put(1'b0, 10 * E);
				put(1'b1, 2 * E);
			end
		end
	end
endmodule
